/* src/mavr_field.sv */
/*
  One storage field of the register bank, loaded when its write strobe
  is high.
  Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none

module mavr_field #(
  parameter int unsigned  W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] value
);

  logic [W-1:0] value_r;
  logic [W-1:0] value_nxt;

  always_comb begin
    value_nxt = wr_en ? wr_data : value_r;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      value_r <= RST;
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;

endmodule

`default_nettype wire

/* src/mavr_pkg.sv */
/*
  Constants for the monitor alert mask and limit register bank: offsets,
  field widths, counts and reset values.
  Assumes a byte-wide register address and 16-bit register words.
*/
// Summary of operation
// - Mask bit 0 passes its status trip to the alert; 1 blocks it.
// - Input masks sit in bits 7:0 at 0x16, 0x17, 0x18; all reset to 1.
// - Temperature mask 0x19: bit3 local high, 2 remote high, 1 local low, 0 remote low.
// - Bit 4 of 0x19 masks the remote diode fault; masked after reset.
// - Each temperature low mask only suppresses its own alert source.
// - 0x1A to 0x29 are read-only 10-bit channel samples, reset zero.
// - 0x2A to 0x35 hold read-write 12-bit DAC codes, reset zero.
// - 0x36 to 0x45 hold read-write 10-bit high limits, reset 0x3FF.
// - Status read drops the alert unless a new unmasked trip arrives in that cycle; cleared status shows only on the next read.
`default_nettype none

package mavr_pkg;

  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 16;

  // -----------------------------------------------------------------
  // Offsets
  // -----------------------------------------------------------------
  localparam logic [7:0]  STATUS_FIRST    = 8'h10;
  localparam logic [7:0]  STATUS_LAST     = 8'h14;
  localparam logic [7:0]  OVER_MASK_HI    = 8'h16;
  localparam logic [7:0]  UNDER_MASK_LO   = 8'h17;
  localparam logic [7:0]  UNDER_MASK_HI   = 8'h18;
  localparam logic [7:0]  TEMP_MASK       = 8'h19;
  localparam logic [7:0]  SAMPLE_BASE     = 8'h1a;
  localparam logic [7:0]  DAC_BASE        = 8'h2a;
  localparam logic [7:0]  LIMIT_BASE      = 8'h36;

  // -----------------------------------------------------------------
  // Counts and widths
  // -----------------------------------------------------------------
  localparam int unsigned CHAN_N          = 16;
  localparam int unsigned DAC_N           = 12;
  localparam int unsigned VMASK_W         = 8;
  localparam int unsigned TMASK_W         = 5;
  localparam int unsigned SAMPLE_W        = 10;
  localparam int unsigned DAC_W           = 12;

  // Temperature mask bit positions
  localparam int unsigned TM_REMOTE_LOW   = 0;
  localparam int unsigned TM_LOCAL_LOW    = 1;
  localparam int unsigned TM_REMOTE_HIGH  = 2;
  localparam int unsigned TM_LOCAL_HIGH   = 3;
  localparam int unsigned TM_DIODE_FAULT  = 4;

  // -----------------------------------------------------------------
  // Reset values
  // -----------------------------------------------------------------
  localparam logic [7:0]  VMASK_RST       = 8'hff;
  localparam logic [4:0]  TMASK_RST       = 5'h1f;
  localparam logic [9:0]  SAMPLE_RST      = 10'h000;
  localparam logic [11:0] DAC_RST         = 12'h000;
  localparam logic [9:0]  LIMIT_RST       = 10'h3ff;

endpackage

`default_nettype wire

/* src/mavr_regs.sv */
/*
  Alert mask, channel sample, DAC code and high limit registers, with the
  alert output gated by the masks.
  Assumes a simple register port fed by the serial interface decoder, and
  trip levels from the status logic that lives outside this bank.
*/
`default_nettype none

module mavr_regs (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_rd,
  output logic      [15:0]  reg_rdata,
  input  wire logic [7:0]   over_trip_hi,
  input  wire logic [15:0]  under_trip,
  input  wire logic [4:0]   temp_trip,
  input  wire logic         sample_valid,
  input  wire logic [3:0]   sample_chan,
  input  wire logic [9:0]   sample_data,
  output logic              alert,
  output logic      [143:0] dac_code,
  output logic      [159:0] high_limit
);

  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  logic [7:0] sample_idx;
  logic [7:0] dac_idx;
  logic [7:0] limit_idx;
  logic       in_sample;
  logic       in_dac;
  logic       in_limit;
  logic       status_rd;

  always_comb begin
    sample_idx = reg_addr - mavr_pkg::SAMPLE_BASE;
    dac_idx    = reg_addr - mavr_pkg::DAC_BASE;
    limit_idx  = reg_addr - mavr_pkg::LIMIT_BASE;
    in_sample  = (reg_addr >= mavr_pkg::SAMPLE_BASE) && (sample_idx < 8'(mavr_pkg::CHAN_N));
    in_dac     = (reg_addr >= mavr_pkg::DAC_BASE) && (dac_idx < 8'(mavr_pkg::DAC_N));
    in_limit   = (reg_addr >= mavr_pkg::LIMIT_BASE) && (limit_idx < 8'(mavr_pkg::CHAN_N));
    status_rd  = reg_rd && (reg_addr >= mavr_pkg::STATUS_FIRST)
                 && (reg_addr <= mavr_pkg::STATUS_LAST);
  end

  // -----------------------------------------------------------------
  // Mask registers
  // -----------------------------------------------------------------
  logic [7:0] vmask_q [3];
  logic [4:0] tmask_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_vmask
      mavr_field #(
        .W   (mavr_pkg::VMASK_W),
        .RST (mavr_pkg::VMASK_RST)
      ) u_vmask (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (reg_wr && (reg_addr == mavr_pkg::OVER_MASK_HI + 8'(gi))),
        .wr_data (reg_wdata[7:0]),
        .value   (vmask_q[gi])
      );
    end
  endgenerate

  mavr_field #(
    .W   (mavr_pkg::TMASK_W),
    .RST (mavr_pkg::TMASK_RST)
  ) u_tmask (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (reg_wr && (reg_addr == mavr_pkg::TEMP_MASK)),
    .wr_data (reg_wdata[4:0]),
    .value   (tmask_q)
  );

  // -----------------------------------------------------------------
  // Sample, DAC and limit arrays
  // -----------------------------------------------------------------
  logic [9:0]  sample_q [16];
  logic [11:0] dac_q    [12];
  logic [9:0]  limit_q  [16];

  generate
    for (gi = 0; gi < 16; gi++) begin : g_chan
      mavr_field #(
        .W   (mavr_pkg::SAMPLE_W),
        .RST (mavr_pkg::SAMPLE_RST)
      ) u_sample (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (sample_valid && (sample_chan == 4'(gi))),
        .wr_data (sample_data),
        .value   (sample_q[gi])
      );
      mavr_field #(
        .W   (mavr_pkg::SAMPLE_W),
        .RST (mavr_pkg::LIMIT_RST)
      ) u_limit (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (reg_wr && in_limit && (limit_idx[3:0] == 4'(gi))),
        .wr_data (reg_wdata[9:0]),
        .value   (limit_q[gi])
      );
      assign high_limit[gi*10 +: 10] = limit_q[gi];
    end
    for (gi = 0; gi < 12; gi++) begin : g_dac
      mavr_field #(
        .W   (mavr_pkg::DAC_W),
        .RST (mavr_pkg::DAC_RST)
      ) u_dac (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (reg_wr && in_dac && (dac_idx[3:0] == 4'(gi))),
        .wr_data (reg_wdata[11:0]),
        .value   (dac_q[gi])
      );
      assign dac_code[gi*12 +: 12] = dac_q[gi];
    end
  endgenerate

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = 16'h0000;
      if (reg_addr == mavr_pkg::OVER_MASK_HI) begin
        rdata_nxt[7:0] = vmask_q[0];
      end else if (reg_addr == mavr_pkg::UNDER_MASK_LO) begin
        rdata_nxt[7:0] = vmask_q[1];
      end else if (reg_addr == mavr_pkg::UNDER_MASK_HI) begin
        rdata_nxt[7:0] = vmask_q[2];
      end else if (reg_addr == mavr_pkg::TEMP_MASK) begin
        rdata_nxt[4:0] = tmask_q;
      end else if (in_sample) begin
        rdata_nxt[9:0] = sample_q[sample_idx[3:0]];
      end else if (in_dac) begin
        rdata_nxt[11:0] = dac_q[dac_idx[3:0]];
      end else if (in_limit) begin
        rdata_nxt[9:0] = limit_q[limit_idx[3:0]];
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // -----------------------------------------------------------------
  // Alert
  // -----------------------------------------------------------------
  logic [28:0] pending;
  logic [28:0] pending_r;
  logic [28:0] fresh;
  logic        alert_r;
  logic        alert_nxt;

  always_comb begin
    pending   = {over_trip_hi & ~vmask_q[0],
                 under_trip[7:0] & ~vmask_q[1],
                 under_trip[15:8] & ~vmask_q[2],
                 temp_trip & ~tmask_q};
    fresh     = pending & ~pending_r;
    alert_nxt = alert_r;
    if (status_rd) begin
      alert_nxt = 1'b0;
    end
    if (fresh != 29'h0000_0000) begin
      alert_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pending_r <= 29'h0000_0000;
      alert_r   <= 1'b0;
    end else begin
      pending_r <= pending;
      alert_r   <= alert_nxt;
    end
  end

  assign alert = alert_r;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_alert_set;
    (fresh != 29'h0000_0000) |=> alert;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("unmasked trip missed");

  property p_alert_cause;
    $rose(alert) |-> $past(fresh) != 29'h0000_0000;
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without cause");

  property p_vmask_wr;
    reg_wr && (reg_addr == mavr_pkg::UNDER_MASK_LO) |=> vmask_q[1] == $past(reg_wdata[7:0]);
  endproperty
  a_vmask_wr: assert property (p_vmask_wr) else $error("input mask write lost");

  property p_tmask_rd;
    reg_wr && (reg_addr == mavr_pkg::TEMP_MASK) ##1 !reg_wr
      ##1 reg_rd && (reg_addr == mavr_pkg::TEMP_MASK)
      |=> reg_rdata == {11'h000, $past(reg_wdata[4:0], 3)};
  endproperty
  a_tmask_rd: assert property (p_tmask_rd) else $error("temp mask readback bad");

  property p_masked_quiet;
    !alert && (pending == 29'h0000_0000) |=> !alert;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked trip raised alert");

  property p_sample;
    sample_valid |=> sample_q[$past(sample_chan)] == $past(sample_data);
  endproperty
  a_sample: assert property (p_sample) else $error("sample not stored");

  property p_dac_rd;
    reg_rd && (reg_addr == mavr_pkg::DAC_BASE) |=> reg_rdata == {4'h0, dac_q[0]};
  endproperty
  a_dac_rd: assert property (p_dac_rd) else $error("dac readback bad");

  property p_limit_wr;
    reg_wr && (reg_addr == mavr_pkg::LIMIT_BASE + 8'h05)
      |=> high_limit[59:50] == $past(reg_wdata[9:0]);
  endproperty
  a_limit_wr: assert property (p_limit_wr) else $error("limit write lost");

  property p_clear;
    status_rd && (fresh == 29'h0000_0000) |=> !alert;
  endproperty
  a_clear: assert property (p_clear) else $error("status read kept alert");

  property p_reserved;
    reg_rdata[15:12] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule

`default_nettype wire

/* testbench/mavr_host.sv */
/*
  Host model for the bank's register port: one-cycle write and read strobes.
  Assumes the bank registers a read's answer on the edge that takes it.
*/
`default_nettype none

module mavr_host (
  input  wire logic        clock,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // Status reads come singly at the bench, the two at 0x10 included, with idle cycles between them
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule

`default_nettype wire

/* testbench/testbench.sv */
/*
  Self-checking bench for the alert mask and limit register bank.
  Assumes mavr_host drives the register port and the bench drives trips.
*/
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic         clock;
  logic         sys_rst;
  logic [7:0]   reg_addr;
  logic         reg_wr;
  logic [15:0]  reg_wdata;
  logic         reg_rd;
  logic [15:0]  reg_rdata;
  logic [7:0]   over_trip_hi;
  logic [15:0]  under_trip;
  logic [4:0]   temp_trip;
  logic         sample_valid;
  logic [3:0]   sample_chan;
  logic [9:0]   sample_data;
  logic         alert;
  logic [143:0] dac_code;
  logic [159:0] high_limit;
  logic [15:0]  rd_val;
  int           fail_count;
  int           checks_done;

  mavr_host host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  mavr_regs dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .over_trip_hi(over_trip_hi), .under_trip(under_trip),
    .temp_trip(temp_trip), .sample_valid(sample_valid),
    .sample_chan(sample_chan), .sample_data(sample_data), .alert(alert),
    .dac_code(dac_code), .high_limit(high_limit));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, rd_val);
    `CHK(rd_val, e)
  endtask

  task automatic alert_chk(input logic e);
    repeat (2) @(posedge clock);
    #1;
    `CHK(alert, e)
  endtask

  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end

  initial begin
    fail_count   = 0;
    checks_done  = 0;
    sys_rst      = 1'b1;
    over_trip_hi = 8'h00;
    under_trip   = 16'h0000;
    temp_trip    = 5'h00;
    sample_valid = 1'b0;
    sample_chan  = 4'h0;
    sample_data  = 10'h000;
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'(8'h16 + i), 16'h00ff);
    end
    rd_chk(8'h19, 16'h001f);
    for (int i = 0; i < 16; i++) begin
      rd_chk(8'(8'h1a + i), 16'h0000);
      rd_chk(8'(8'h36 + i), 16'h03ff);
      if (i < 12) begin
        rd_chk(8'(8'h2a + i), 16'h0000);
      end
    end
    `CHK(dac_code, 144'h0)
    `CHK(high_limit, {16{10'h3ff}})
    $display("test reset done");
    // ------------------------------------------------------------
    // Access kinds and reserved bits
    // ------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      host.wr(8'(8'h16 + i), 16'hff00 | 16'(i == 3 ? 16'h00e0 : 16'h0000));
      rd_chk(8'(8'h16 + i), 16'h0000);
      host.wr(8'(8'h16 + i), 16'hffff);
      rd_chk(8'(8'h16 + i), i == 3 ? 16'h001f : 16'h00ff);
    end
    for (int i = 0; i < 12; i++) begin
      host.wr(8'(8'h2a + i), 16'hf000 | 16'(i * 16'h0111));
      rd_chk(8'(8'h2a + i), 16'(i * 16'h0111));
      `CHK(dac_code[i * 12 +: 12], 12'(i * 12'h111))
    end
    for (int i = 0; i < 16; i++) begin
      host.wr(8'(8'h36 + i), {6'h3f, 4'(i), 6'h15});
      rd_chk(8'(8'h36 + i), {6'h00, 4'(i), 6'h15});
      `CHK(high_limit[i * 10 +: 10], {4'(i), 6'h15})
    end
    host.wr(8'h1a, 16'h0155);
    rd_chk(8'h1a, 16'h0000);
    host.wr(8'h50, 16'h1234);
    rd_chk(8'h50, 16'h0000);
    $display("test access done");
    // ------------------------------------------------------------
    // Sample path, back to back
    // ------------------------------------------------------------
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      #1;
      sample_valid = 1'b1;
      sample_chan  = 4'(i);
      sample_data  = {4'(i), 6'h2a};
    end
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd_chk(8'(8'h1a + i), {6'h00, 4'(i), 6'h2a});
    end
    $display("test samples done");
    // ------------------------------------------------------------
    // Alert masking and clearing
    // ------------------------------------------------------------
    under_trip = 16'h0001;
    alert_chk(1'b0);
    host.wr(8'h17, 16'h00fe);
    alert_chk(1'b1);
    host.rd(8'h10, rd_val);
    alert_chk(1'b0);
    rd_chk(8'h10, 16'h0000);
    alert_chk(1'b0);
    under_trip = 16'h0000;
    host.wr(8'h17, 16'h00ff);
    temp_trip = 5'b10101;
    host.wr(8'h19, 16'h001d);
    alert_chk(1'b0);
    temp_trip = 5'b10111;
    alert_chk(1'b1);
    host.rd(8'h14, rd_val);
    alert_chk(1'b0);
    host.wr(8'h19, 16'h000d);
    alert_chk(1'b1);
    host.rd(8'h14, rd_val);
    alert_chk(1'b0);
    // Local high only unmasked; remote high stays low
    host.wr(8'h19, 16'h0017);
    alert_chk(1'b0);
    temp_trip = 5'b11001;
    alert_chk(1'b1);
    host.rd(8'h14, rd_val);
    alert_chk(1'b0);
    over_trip_hi = 8'h80;
    alert_chk(1'b0);
    host.wr(8'h16, 16'h007f);
    alert_chk(1'b1);
    $display("test alert done");
    wrap_up();
  end
endmodule

`default_nettype wire
